// ===== logic/spm_cfg.svh
/*
 * Constants of the power-mode scheduler: register offsets, field positions,
 * reset values and timing figures.
 * Assumes it is included by its bare name from every scheduler file that uses its macros.
 */
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// register offsets on the internal register port
`define SPM_ADDR_SYS_CTRL    8'hd0
`define SPM_ADDR_STATUS      8'hd1
`define SPM_ADDR_MODE_CTRL   8'hd2
`define SPM_ADDR_NORMAL_PER  8'hd3
`define SPM_ADDR_LP_PER      8'hd4
`define SPM_ADDR_DS_PER      8'hd5
`define SPM_ADDR_IDLE_LIMIT  8'hd6

// field positions
`define SPM_BIT_DS_ENABLE    6
`define SPM_BIT_AUTO_DIS     5
`define SPM_SEL_HI           4
`define SPM_SEL_LO           3
`define SPM_FRAC_HI          2
`define SPM_FRAC_LO          0
`define SPM_BIT_SYS_REDUCED  4
`define SPM_BIT_OTP_REDUCED  2

// state-select codes
`define SPM_SEL_NORMAL       2'h0
`define SPM_SEL_LP           2'h1
`define SPM_SEL_DS           2'h2
`define SPM_SEL_HALT         2'h3

// reset values
`define SPM_RST_SYS_CTRL     8'h00
`define SPM_RST_MODE_CTRL    8'h00
`define SPM_RST_NORMAL_PER   8'h10
`define SPM_RST_LP_PER       8'h40
`define SPM_RST_DS_PER       8'h10
`define SPM_RST_IDLE_LIMIT   8'h14

// timing
`define SPM_CLK_HZ           40000000
`define SPM_OSC_FULL_MHZ     16
`define SPM_OSC_REDUCED_MHZ  4
`define SPM_BASE_MS          1
`define SPM_DS_STEP_MS       16
`define SPM_IDLE_STEP_MS     500
`define SPM_CYC_PER_MS       ((`SPM_CLK_HZ / 1000) * `SPM_BASE_MS)

`endif

// ===== logic/spm_pkg.sv
/*
 * Types shared by the power-mode scheduler modules.
 * Assumes nothing beyond the constants header.
 */
package spm_pkg;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_LOW_POWER,
        ST_DEEP_SLEEP,
        ST_HALT
    } spm_state_t;

    // one access on the internal register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spm_reg_req_t;

    // decoded software settings
    typedef struct packed {
        logic       reduced_sw;
        logic       ds_enable;
        logic       auto_dis;
        logic [1:0] sel;
        logic [2:0] frac;
        logic [7:0] normal_per;
        logic [7:0] lp_per;
        logic [7:0] ds_per;
        logic [7:0] idle_limit;
    } spm_ctrl_t;

endpackage

// ===== logic/spm_tick.sv
/*
 * Timebase: 1 ms, 16 ms and 500 ms ticks from the fixed reference clock.
 * Assumes a free-running clock and a clock enable that freezes it.
 */
`include "spm_cfg.svh"

module spm_tick #(
    parameter int CYC_PER_MS = `SPM_CYC_PER_MS
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic ce,
    // ticks, one cycle each
    output logic      tick_1ms,
    output logic      tick_16ms,
    output logic      tick_500ms
);
    localparam int CW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;

    logic [CW-1:0] cyc_ff;
    logic [3:0]    ms16_ff;
    logic [8:0]    ms500_ff;

    assign tick_1ms   = ce && (cyc_ff == CW'(CYC_PER_MS - 1));
    assign tick_16ms  = tick_1ms && (ms16_ff == 4'(`SPM_DS_STEP_MS - 1));
    assign tick_500ms = tick_1ms && (ms500_ff == 9'(`SPM_IDLE_STEP_MS - 1));

    // cycle prescaler; counts reference cycles, not oscillator cycles
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cyc_ff <= '0;
        end else if (ce) begin
            cyc_ff <= tick_1ms ? '0 : cyc_ff + CW'(1);
        end
    end

    // millisecond dividers for the slow step sizes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ms16_ff  <= 4'h0;
            ms500_ff <= 9'h000;
        end else if (tick_1ms) begin
            ms16_ff  <= tick_16ms ? 4'h0 : ms16_ff + 4'h1;
            ms500_ff <= tick_500ms ? 9'h000 : ms500_ff + 9'h001;
        end
    end
endmodule

// ===== logic/spm_regs.sv
/*
 * Register file of the power-mode scheduler.
 * Assumes the serial-bus front end presents one-cycle rd/wr strobes.
 */
`include "spm_cfg.svh"

module spm_regs (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic                 ce,
    // register port
    input  wire spm_pkg::spm_reg_req_t req,
    output logic [7:0]                rdata_ff,
    // block side
    input  wire logic [7:0]           status,
    output spm_pkg::spm_ctrl_t        ctrl
);
    logic [7:0] sys_ff, mode_ff, nper_ff, lper_ff, dper_ff, idle_ff;

    // writes; status is read-only and ignores writes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sys_ff  <= `SPM_RST_SYS_CTRL;
            mode_ff <= `SPM_RST_MODE_CTRL;
            nper_ff <= `SPM_RST_NORMAL_PER;
            lper_ff <= `SPM_RST_LP_PER;
            dper_ff <= `SPM_RST_DS_PER;
            idle_ff <= `SPM_RST_IDLE_LIMIT;
        end else if (ce && req.wr) begin
            if (req.addr == `SPM_ADDR_SYS_CTRL) begin
                sys_ff <= req.wdata;
            end else if (req.addr == `SPM_ADDR_MODE_CTRL) begin
                mode_ff <= req.wdata;
            end else if (req.addr == `SPM_ADDR_NORMAL_PER) begin
                nper_ff <= req.wdata;
            end else if (req.addr == `SPM_ADDR_LP_PER) begin
                lper_ff <= req.wdata;
            end else if (req.addr == `SPM_ADDR_DS_PER) begin
                dper_ff <= req.wdata;
            end else if (req.addr == `SPM_ADDR_IDLE_LIMIT) begin
                idle_ff <= req.wdata;
            end
        end
    end

    // read data, registered; unmapped addresses read zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else if (ce && req.rd) begin
            if (req.addr == `SPM_ADDR_SYS_CTRL) begin
                rdata_ff <= sys_ff;
            end else if (req.addr == `SPM_ADDR_STATUS) begin
                rdata_ff <= status;
            end else if (req.addr == `SPM_ADDR_MODE_CTRL) begin
                rdata_ff <= mode_ff;
            end else if (req.addr == `SPM_ADDR_NORMAL_PER) begin
                rdata_ff <= nper_ff;
            end else if (req.addr == `SPM_ADDR_LP_PER) begin
                rdata_ff <= lper_ff;
            end else if (req.addr == `SPM_ADDR_DS_PER) begin
                rdata_ff <= dper_ff;
            end else if (req.addr == `SPM_ADDR_IDLE_LIMIT) begin
                rdata_ff <= idle_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // field decode
    assign ctrl.reduced_sw = sys_ff[`SPM_BIT_SYS_REDUCED];
    assign ctrl.ds_enable  = mode_ff[`SPM_BIT_DS_ENABLE];
    assign ctrl.auto_dis   = mode_ff[`SPM_BIT_AUTO_DIS];
    assign ctrl.sel        = mode_ff[`SPM_SEL_HI:`SPM_SEL_LO];
    assign ctrl.frac       = mode_ff[`SPM_FRAC_HI:`SPM_FRAC_LO];
    assign ctrl.normal_per = nper_ff;
    assign ctrl.lp_per     = lper_ff;
    assign ctrl.ds_per     = dper_ff;
    assign ctrl.idle_limit = idle_ff;
endmodule

// ===== logic/spm_sched.sv
/*
 * Power-mode and report-rate scheduler, top level.
 * Assumes a 40 MHz reference clock, a register port driven by the serial
 * bus front end on the same clock, and activation flags from the sensing
 * engine on the same clock. The option bank arrives from pins.
 */
`include "spm_cfg.svh"

module spm_sched #(
    parameter int CYC_PER_MS = `SPM_CYC_PER_MS,
    parameter int CHANNELS   = 6
) (
    // clock, reset, enable
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic                  ce,
    // register port from the serial bus front end
    input  wire spm_pkg::spm_reg_req_t reg_req,
    output logic [7:0]                 reg_rdata_ff,
    // option bank pins
    input  wire logic [7:0]            otp_bank,
    // sensing engine
    input  wire logic                  activation,
    input  wire logic                  ch0_prox,
    output logic                       sense_start_ff,
    output logic [CHANNELS-1:0]        sense_mask_ff,
    output logic                       full_update_cycle_ff,
    // oscillator control
    output logic                       osc_enable_ff,
    output logic                       osc_reduced_ff,
    output logic                       osc_slow_sense_ff,
    // state
    output spm_pkg::spm_state_t        op_state_ff
);
    spm_pkg::spm_ctrl_t  ctrl;
    spm_pkg::spm_state_t nxt_state;
    spm_pkg::spm_state_t sel_state;
    logic       tick_1ms, tick_16ms, tick_500ms;
    logic [7:0] otp_meta_ff, otp_sync_ff;
    logic       otp_taken_ff, otp_reduced_ff;
    logic [1:0] otp_fill_ff;
    logic [7:0] period_cnt_ff;
    logic [7:0] idle_cnt_ff;
    logic [7:0] full_cnt_ff;
    logic [7:0] full_last;
    logic [7:0] period_lim;
    logic       period_tick;
    logic       period_due;
    logic       idle_expired;
    logic       state_change;
    logic [7:0] status;

    // status byte: state in bits 1..0, clock choice in bit 2
    assign status = {5'h00, osc_reduced_ff, op_state_ff};

    spm_regs u_regs (
        .clock    (clock),
        .reset_n  (reset_n),
        .ce       (ce),
        .req      (reg_req),
        .rdata_ff (reg_rdata_ff),
        .status   (status),
        .ctrl     (ctrl)
    );

    // timebase runs from the fixed reference, so it is unaffected by the
    // oscillator choice and rates stay the same in both clock modes
    spm_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_tick (
        .clock      (clock),
        .reset_n    (reset_n),
        .ce         (ce),
        .tick_1ms   (tick_1ms),
        .tick_16ms  (tick_16ms),
        .tick_500ms (tick_500ms)
    );

    // option bank pins: two-stage synchroniser
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            otp_meta_ff <= 8'h00;
            otp_sync_ff <= 8'h00;
        end else if (ce) begin
            otp_meta_ff <= otp_bank;
            otp_sync_ff <= otp_meta_ff;
        end
    end

    // option bit caught once, after two enabled edges have filled the
    // synchroniser; the pins are fuses, so a later change waits for reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            otp_fill_ff    <= 2'h0;
            otp_taken_ff   <= 1'b0;
            otp_reduced_ff <= 1'b0;
        end else if (ce && !otp_taken_ff) begin
            if (otp_fill_ff == 2'h2) begin
                otp_taken_ff   <= 1'b1;
                otp_reduced_ff <= otp_sync_ff[`SPM_BIT_OTP_REDUCED];
            end else begin
                otp_fill_ff <= otp_fill_ff + 2'h1;
            end
        end
    end

    // oscillator: on and at full rate by default, quarter rate when either
    // the fuse or the software bit asks for it; off only while dormant
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            osc_enable_ff  <= 1'b1;
            osc_reduced_ff <= 1'b0;
        end else if (ce) begin
            osc_enable_ff  <= (op_state_ff != spm_pkg::ST_HALT);
            osc_reduced_ff <= ctrl.reduced_sw || otp_reduced_ff;
        end
    end

    // decode of the fixed-state select field; deep sleep falls back to
    // low power when it has not been enabled
    always_comb begin
        case (ctrl.sel)
            `SPM_SEL_NORMAL: sel_state = spm_pkg::ST_NORMAL;
            `SPM_SEL_LP:     sel_state = spm_pkg::ST_LOW_POWER;
            `SPM_SEL_DS:     sel_state = ctrl.ds_enable ? spm_pkg::ST_DEEP_SLEEP
                                                       : spm_pkg::ST_LOW_POWER;
            default:         sel_state = spm_pkg::ST_HALT;
        endcase
    end

    assign idle_expired = tick_500ms && (idle_cnt_ff >= ctrl.idle_limit);

    // next state: fixed selection when automatic switching is off, else
    // the demotion chain and the wake-ups
    always_comb begin
        nxt_state = op_state_ff;
        if (ctrl.auto_dis) begin
            nxt_state = sel_state;
        end else begin
            case (op_state_ff)
                spm_pkg::ST_NORMAL: begin
                    if (idle_expired) begin
                        nxt_state = spm_pkg::ST_LOW_POWER;
                    end
                end
                spm_pkg::ST_LOW_POWER: begin
                    if (activation) begin
                        nxt_state = spm_pkg::ST_NORMAL;
                    end else if (idle_expired && ctrl.ds_enable) begin
                        nxt_state = spm_pkg::ST_DEEP_SLEEP;
                    end
                end
                spm_pkg::ST_DEEP_SLEEP: begin
                    if (ch0_prox || !ctrl.ds_enable) begin
                        nxt_state = spm_pkg::ST_NORMAL;
                    end
                end
                default: begin
                    nxt_state = spm_pkg::ST_HALT;
                end
            endcase
        end
    end

    assign state_change = (nxt_state != op_state_ff);

    // operating state register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            op_state_ff <= spm_pkg::ST_NORMAL;
        end else if (ce) begin
            op_state_ff <= nxt_state;
        end
    end

    // inactivity timer in 500 ms steps; only normal and low power demote
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            idle_cnt_ff <= 8'h00;
        end else if (ce) begin
            if (activation || state_change) begin
                idle_cnt_ff <= 8'h00;
            end else if (tick_500ms && idle_cnt_ff != 8'hff) begin
                idle_cnt_ff <= idle_cnt_ff + 8'h01;
            end
        end
    end

    // period source: 1 ms steps awake, 16 ms steps in deep sleep
    always_comb begin
        case (op_state_ff)
            spm_pkg::ST_NORMAL: begin
                period_tick = tick_1ms;
                period_lim  = ctrl.normal_per;
            end
            spm_pkg::ST_LOW_POWER: begin
                period_tick = tick_1ms;
                period_lim  = ctrl.lp_per;
            end
            spm_pkg::ST_DEEP_SLEEP: begin
                period_tick = tick_16ms;
                period_lim  = ctrl.ds_per;
            end
            default: begin
                period_tick = 1'b0;
                period_lim  = 8'h00;
            end
        endcase
    end

    // a period of zero starts a cycle on every step
    assign period_due = period_tick && (period_cnt_ff >= period_lim);

    // report period counter, restarted on a state change so a new state
    // always begins with a full period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            period_cnt_ff <= 8'h00;
        end else if (ce) begin
            if (state_change || period_due) begin
                period_cnt_ff <= 8'h00;
            end else if (period_tick) begin
                period_cnt_ff <= period_cnt_ff + 8'h01;
            end
        end
    end

    // full-update fraction: 2^(frac+1) deep sleep cycles per full update
    assign full_last = 8'((9'h002 << ctrl.frac) - 9'h001);

    // deep sleep cycle counter for the full updates
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            full_cnt_ff <= 8'h00;
        end else if (ce) begin
            if (op_state_ff != spm_pkg::ST_DEEP_SLEEP) begin
                full_cnt_ff <= 8'h00;
            end else if (period_due) begin
                full_cnt_ff <= (full_cnt_ff >= full_last) ? 8'h00
                                                          : full_cnt_ff + 8'h01;
            end
        end
    end

    // sensing start and channel set; halt never starts a cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sense_start_ff       <= 1'b0;
            sense_mask_ff        <= '0;
            full_update_cycle_ff <= 1'b0;
        end else if (ce) begin
            sense_start_ff <= period_due && !state_change;
            if (period_due && !state_change) begin
                if (op_state_ff == spm_pkg::ST_DEEP_SLEEP
                        && full_cnt_ff < full_last) begin
                    sense_mask_ff        <= CHANNELS'(1);
                    full_update_cycle_ff <= 1'b0;
                end else begin
                    sense_mask_ff        <= '1;
                    full_update_cycle_ff <= (op_state_ff == spm_pkg::ST_DEEP_SLEEP);
                end
            end
        end
    end

    // low power senses with the slower oscillator setting
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            osc_slow_sense_ff <= 1'b0;
        end else if (ce) begin
            osc_slow_sense_ff <= (nxt_state == spm_pkg::ST_LOW_POWER);
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_enter_halt;
        op_state_ff != spm_pkg::ST_HALT ##1 op_state_ff == spm_pkg::ST_HALT;
    endsequence

    sequence s_leave_halt;
        op_state_ff == spm_pkg::ST_HALT ##1 op_state_ff != spm_pkg::ST_HALT;
    endsequence

    a_halt_entry_manual: assert property (s_enter_halt |-> $past(ctrl.auto_dis))
        else $error("halt entered with automatic switching on");

    a_halt_exit_manual: assert property (s_leave_halt |-> $past(ctrl.auto_dis))
        else $error("halt left with automatic switching on");

    a_halt_no_sense: assert property (
        op_state_ff == spm_pkg::ST_HALT ##1 op_state_ff == spm_pkg::ST_HALT
        |-> !sense_start_ff)
        else $error("sensing started while halted");

    a_deep_needs_enable: assert property (
        op_state_ff == spm_pkg::ST_DEEP_SLEEP |-> ctrl.ds_enable || $past(ctrl.ds_enable))
        else $error("deep sleep without enable");

    a_deep_mask_shape: assert property (
        sense_start_ff && full_update_cycle_ff == 1'b0
        && $past(op_state_ff) == spm_pkg::ST_DEEP_SLEEP |-> sense_mask_ff == CHANNELS'(1))
        else $error("deep sleep cycle sensed more than channel 0");

    a_prox_wakeup: assert property (
        ce && !ctrl.auto_dis && op_state_ff == spm_pkg::ST_DEEP_SLEEP && ch0_prox
        |=> op_state_ff == spm_pkg::ST_NORMAL)
        else $error("channel 0 proximity did not wake to normal");

    a_reduced_clock: assert property (
        ce && (ctrl.reduced_sw || otp_reduced_ff) |=> osc_reduced_ff)
        else $error("reduced clock not applied");

    a_manual_select: assert property (
        ce && ctrl.auto_dis && ctrl.sel == `SPM_SEL_LP
        |=> op_state_ff == spm_pkg::ST_LOW_POWER)
        else $error("fixed state select not followed");

    a_idle_restart: assert property (
        ce && activation |=> idle_cnt_ff == 8'h00)
        else $error("inactivity timer not restarted");

    a_normal_demote: assert property (
        ce && !ctrl.auto_dis && op_state_ff == spm_pkg::ST_NORMAL && idle_expired
        |=> op_state_ff == spm_pkg::ST_LOW_POWER ##1 idle_cnt_ff == 8'h00 || !ce)
        else $error("normal did not step down on inactivity");
endmodule

// ===== verif/spm_host.sv
/* host model: one-cycle register strobes toward the scheduler.
   assumes the scheduler samples its register port on the rising clock. */
module spm_host (
    // clock
    input  wire logic             clock,
    // register port
    output spm_pkg::spm_reg_req_t req,
    input  wire logic [7:0]       rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // idle fields go inverted so the scheduler cannot lean on stale values
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clock);
        req <= '{w, !w, a, d};
        @(posedge clock);
        req <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge clock);
        #1 q = rdata;
    endtask
endmodule

// ===== verif/spm_sched_tb.sv
/* bench for the power-mode scheduler: host model, expected state, checks.
   assumes the offsets and reset values of the constants header. */
`include "spm_cfg.svh"
module spm_sched_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clock = 0, reset_n = 0, activation = 0, ch0_prox = 0, ce = 1;
    logic [7:0]            q, rdata, otp = 8'h00;
    logic                  go, full, osc_en, osc_red, osc_slow;
    logic [5:0]            mask;
    spm_pkg::spm_reg_req_t req;
    spm_pkg::spm_state_t   st;
    int                    n_errors = 0, comparisons = 0, seed = 32'h65c44a5d, n, nf, exp_st;
    always #12.5 clock = ~clock;
    // 4 cycles a millisecond keeps the long timers short
    spm_sched #(.CYC_PER_MS(4)) u_spm_sched (.clock(clock), .reset_n(reset_n), .ce(ce),
        .reg_req(req), .reg_rdata_ff(rdata), .otp_bank(otp), .activation(activation),
        .ch0_prox(ch0_prox), .sense_start_ff(go), .sense_mask_ff(mask),
        .full_update_cycle_ff(full), .osc_enable_ff(osc_en), .osc_reduced_ff(osc_red),
        .osc_slow_sense_ff(osc_slow), .op_state_ff(st));
    spm_host u_spm_host (.clock(clock), .req(req), .rdata(rdata));
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_spm_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, e);
        u_spm_host.xfer(1'b0, a, 8'h00, q);
        chk("read data", e, q);
    endtask
    // bounded wait for a start pulse or the expected state; n counts cycles
    task automatic wait_for(input bit on_st, input int lim);
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (n < lim && (on_st ? st !== spm_pkg::spm_state_t'(exp_st) : go !== 1'b1));
        if (n >= lim) begin
            chk("wait limit", 8'h00, 8'h01);
            report_and_stop();
        end
    endtask
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        #1 chk("state", 8'h00, 8'(st));
        chk("osc on", 8'h01, 8'(osc_en));
        rd(`SPM_ADDR_MODE_CTRL, `SPM_RST_MODE_CTRL);
        rd(`SPM_ADDR_NORMAL_PER, `SPM_RST_NORMAL_PER);
        rd(`SPM_ADDR_LP_PER, `SPM_RST_LP_PER);
        rd(`SPM_ADDR_DS_PER, `SPM_RST_DS_PER);
        rd(`SPM_ADDR_IDLE_LIMIT, `SPM_RST_IDLE_LIMIT);
        rd(8'he7, 8'h00);
        // normal then low power, random periods measured between two starts
        for (int m = 0; m < 2; m++) begin
            wr(`SPM_ADDR_MODE_CTRL, m ? 8'h28 : 8'h20);
            repeat (3) begin
                nf = $random(seed) & 7;
                wr(m ? `SPM_ADDR_LP_PER : `SPM_ADDR_NORMAL_PER, 8'(nf));
                wait_for(0, 2000);
                wait_for(0, 2000);
                chk("period", 8'((nf + 1) * 4), 8'(n));
                chk("mask", 8'h3f, 8'(mask));
                chk("slow osc", 8'(m), 8'(osc_slow));
            end
        end
        // every select code, first with deep sleep disabled, ending in halt
        for (int i = 0; i < 8; i++) begin
            exp_st = (i == 2) ? 1 : i % 4;
            wr(`SPM_ADDR_MODE_CTRL, 8'(8'h20 | (i / 4) << 6 | (i % 4) << 3));
            chk("state", 8'(exp_st), 8'(st));
            if (i % 4 == 3) begin
                nf = 0;
                repeat (300) begin
                    @(posedge clock);
                    #1 nf += go;
                end
                chk("halt starts", 8'h00, 8'(nf));
                chk("osc on", 8'h00, 8'(osc_en));
            end
        end
        // deep sleep at 16 ms steps, full updates every second then every fourth cycle
        wr(`SPM_ADDR_DS_PER, 8'h00);
        for (int f = 0; f < 2; f++) begin
            wr(`SPM_ADDR_MODE_CTRL, 8'(8'h70 | f));
            wait_for(0, 1000);
            nf = 0;
            repeat (4) begin
                wait_for(0, 1000);
                chk("ds period", 8'h40, 8'(n));
                chk("ds mask", full ? 8'h3f : 8'h01, 8'(mask));
                nf += full;
            end
            chk("full updates", 8'(2 >> f), 8'(nf));
        end
        // automatic switching back on; channel 0 proximity wakes the device
        wr(`SPM_ADDR_MODE_CTRL, 8'h40);
        @(posedge clock) ch0_prox <= 1'b1;
        @(posedge clock) ch0_prox <= 1'b0;
        #1 chk("state", 8'h00, 8'(st));
        // random activity holds normal; silence then steps down twice
        wr(`SPM_ADDR_IDLE_LIMIT, 8'h01);
        repeat (12) begin
            repeat (($random(seed) & 8'hff) + 1) @(posedge clock);
            activation <= 1'b1;
            @(posedge clock) activation <= 1'b0;
        end
        #1 chk("state", 8'h00, 8'(st));
        exp_st = 1;
        wait_for(1, 5000);
        exp_st = 2;
        wait_for(1, 5000);
        // reduced clock keeps the deep-sleep period
        wr(`SPM_ADDR_SYS_CTRL, 8'h10);
        chk("osc reduced", 8'h01, 8'(osc_red));
        rd(`SPM_ADDR_STATUS, 8'h06);
        wait_for(0, 1000);
        wait_for(0, 1000);
        chk("ds period", 8'h40, 8'(n));
        // clock enable low freezes the deep-sleep pacing
        @(posedge clock) ce <= 1'b0;
        nf = 0;
        repeat (100) begin
            @(posedge clock);
            #1 nf += go;
        end
        chk("frozen starts", 8'h00, 8'(nf));
        // mid-run reset with the fuse set: reduced clock without the software bit
        @(posedge clock) ce <= 1'b1;
        otp <= 8'h04;
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk("state", 8'h00, 8'(st));
        chk("fuse clock", 8'h01, 8'(osc_red));
        report_and_stop();
    end
endmodule
